// ---- logic/cldec_pkg.sv ----
package cldec_pkg;
	// apb map: offset 0 is the instruction side, offset 4 the data side
	localparam logic [7:0]  OFF_INSTR     = 8'h00;
	localparam logic [7:0]  OFF_DATA      = 8'h04;
	// timing
	localparam int          CLK_NS        = 25;
	localparam int          T_STD_NS      = 40000;
	localparam int          T_CLEAR_NS    = 1640000;
	localparam int          T_HOME_NS     = 1600000;
	localparam int          T_BLINK_NS    = 409600000;
	localparam int          STD_CYC       = T_STD_NS / CLK_NS;
	localparam int          CLEAR_CYC     = T_CLEAR_NS / CLK_NS;
	localparam int          HOME_CYC      = T_HOME_NS / CLK_NS;
	localparam int          BLINK_CYC     = T_BLINK_NS / CLK_NS;
	// memory geometry and codes
	localparam int          SCREEN_DEPTH  = 128;
	localparam int          GLYPH_DEPTH   = 64;
	localparam logic [7:0]  SPACE_CODE    = 8'h20;
	localparam logic [6:0]  ROW2_BASE     = 7'h40;
	localparam logic [6:0]  ROW1_LAST     = 7'h27;
	localparam logic [6:0]  ROW2_LAST     = 7'h67;
	localparam logic [6:0]  ONE_LAST      = 7'h4F;
	localparam logic [6:0]  LEN_TWO       = 7'h28;
	localparam logic [6:0]  LEN_ONE       = 7'h50;
	localparam logic [3:0]  MARK_ROW_SHORT = 4'h7;
	localparam logic [3:0]  MARK_ROW_TALL  = 4'hA;
	// control bit positions
	localparam int          B_VISIBLE     = 2;
	localparam int          B_MARK        = 1;
	localparam int          B_FLASH       = 0;
	localparam int          B_PAN         = 3;
	localparam int          B_RIGHT       = 2;
	localparam int          B_WIDTH       = 4;
	localparam int          B_TWO         = 3;
	localparam int          B_TALL        = 2;
	localparam int          B_STEPUP      = 1;
	localparam int          B_AUTOPAN     = 0;
	// reset values
	localparam logic        RST_WIDTH     = 1'b1;
	localparam logic        RST_STEPUP    = 1'b1;

	typedef enum logic [3:0] {
		CLD_NONE, CLD_CLEAR, CLD_HOME, CLD_ENTRY, CLD_ONOFF,
		CLD_SHIFT, CLD_FUNC, CLD_GLYPH, CLD_SCREEN
	} cldec_cmd_t;
endpackage

// ---- logic/cldec_top.sv ----
// Local design decisions: register access over APB and the address map.
`timescale 1ns/1ps
module cldec_top
	import cldec_pkg::*;
#(
	parameter int CLEAR_CYCLES = CLEAR_CYC,
	parameter int HOME_CYCLES  = HOME_CYC,
	parameter int BLINK_CYCLES = BLINK_CYC
) (
	// clock and reset
	input  wire  logic        pclk,
	input  wire  logic        presetn,
	// apb slave
	input  wire  logic [7:0]  paddr,
	input  wire  logic        psel,
	input  wire  logic        penable,
	input  wire  logic        pwrite,
	input  wire  logic [31:0] pwdata,
	output logic [31:0]       prdata,
	output logic              pready,
	output logic              pslverr,
	// display scan
	input  wire  logic        scan_row,
	input  wire  logic [6:0]  scan_col,
	input  wire  logic [5:0]  glyph_scan_addr,
	output logic [7:0]        scan_char_q,
	output logic              scan_blank_q,
	output logic              scan_mark_q,
	output logic [7:0]        glyph_row_q,
	// state
	output logic              internal_work_flag,
	output logic              panel_visible_on,
	output logic              pointer_mark_shown,
	output logic              char_flash_on,
	output logic              bus_width_sel,
	output logic              two_row_layout,
	output logic              glyph_tall_sel,
	output logic [6:0]        ram_pointer,
	output logic [6:0]        pan_offset_q,
	output logic [3:0]        mark_dot_row,
	output logic              flash_phase_q
);

	logic [7:0]  screen_text_mem   [SCREEN_DEPTH];
	logic [7:0]  glyph_pattern_mem [GLYPH_DEPTH];
	logic [31:0] prdata_q;
	logic [16:0] busy_cnt_q;
	logic [7:0]  clr_cnt_q;
	logic [23:0] blink_cnt_q;
	logic [3:0]  hi_nib_q;
	logic        nib_q;
	logic        glyph_sel_q;
	logic        step_up_dir_q;
	logic        auto_pan_q;
	logic        vis_q, mark_q, flash_q, width_q, two_q, tall_q;
	logic [6:0]  ptr_q;
	logic        acc, mapped, rs, stat_rd, go, full;
	logic        cmd_wr, dat_wr, dat_rd;
	logic [7:0]  wbyte, rbyte;
	logic [6:0]  line_len;
	cldec_cmd_t  cmd;

	function automatic cldec_cmd_t decode(input logic [7:0] b);
		cldec_cmd_t c;
		c = CLD_NONE;
		if (b[7])
			c = CLD_SCREEN;
		else if (b[6])
			c = CLD_GLYPH;
		else if (b[5])
			c = CLD_FUNC;
		else if (b[4])
			c = CLD_SHIFT;
		else if (b[3])
			c = CLD_ONOFF;
		else if (b[2])
			c = CLD_ENTRY;
		else if (b[1])
			c = CLD_HOME;
		else if (b[0])
			c = CLD_CLEAR;
		return c;
	endfunction

	// one address step; screen addresses skip the gap between rows
	function automatic logic [6:0] step(input logic [6:0] p, input logic up,
			input logic glyph, input logic two);
		logic [6:0] n;
		n = up ? p + 7'd1 : p - 7'd1;
		if (glyph)
			n = {1'b0, n[5:0]};
		else if (two) begin
			if (up && p == ROW1_LAST)
				n = ROW2_BASE;
			else if (up && p == ROW2_LAST)
				n = 7'd0;
			else if (!up && p == ROW2_BASE)
				n = ROW1_LAST;
			else if (!up && p == 7'd0)
				n = ROW2_LAST;
		end else begin
			if (up && p == ONE_LAST)
				n = 7'd0;
			else if (!up && p == 7'd0)
				n = ONE_LAST;
		end
		return n;
	endfunction

	function automatic logic [6:0] pan_step(input logic [6:0] o, input logic left,
			input logic [6:0] len);
		logic [6:0] n;
		if (left)
			n = (o == len - 7'd1) ? 7'd0 : o + 7'd1;
		else
			n = (o == 7'd0) ? len - 7'd1 : o - 7'd1;
		return n;
	endfunction

	assign acc      = psel & penable;
	assign mapped   = (paddr == OFF_INSTR) | (paddr == OFF_DATA);
	assign rs       = (paddr == OFF_DATA);
	assign stat_rd  = !rs & !pwrite;
	// only the status read passes while busy
	assign go       = acc & mapped & (stat_rd | !internal_work_flag);
	// a byte completes on the second half in narrow mode
	assign full     = go & (width_q | nib_q);
	assign wbyte    = width_q ? pwdata[7:0] : {hi_nib_q, pwdata[7:4]};
	assign cmd_wr   = full & pwrite & !rs;
	assign dat_wr   = full & pwrite & rs;
	assign dat_rd   = full & !pwrite & rs;
	assign cmd      = decode(wbyte);
	assign line_len = two_q ? LEN_TWO : LEN_ONE;
	assign rbyte    = rs ? (glyph_sel_q ? glyph_pattern_mem[ptr_q[5:0]]
		: screen_text_mem[ptr_q]) : {internal_work_flag, ptr_q};

	// zero wait states: read data is captured in the setup cycle
	assign pready   = 1'b1;
	assign pslverr  = acc & !mapped;
	assign prdata   = prdata_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata_q <= 32'h0000_0000;
		else if (psel && !penable) begin
			if (!mapped || (rs && internal_work_flag))
				prdata_q <= 32'h0000_0000;
			else if (width_q)
				prdata_q <= {24'h00_0000, rbyte};
			// high half first, then low half
			else
				prdata_q <= {24'h00_0000, (nib_q ? rbyte[3:0] : rbyte[7:4]), 4'h0};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nib_q    <= 1'b0;
			hi_nib_q <= 4'h0;
		end else if (go && !width_q) begin
			nib_q    <= !nib_q;
			hi_nib_q <= pwdata[7:4];
		end else if (width_q)
			nib_q    <= 1'b0;
	end

	// execution time; an undefined code still occupies the standard time
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			busy_cnt_q <= 17'd0;
		else if (cmd_wr && cmd == CLD_CLEAR)
			busy_cnt_q <= 17'(CLEAR_CYCLES);
		else if (cmd_wr && cmd == CLD_HOME)
			busy_cnt_q <= 17'(HOME_CYCLES);
		else if (cmd_wr || dat_wr || dat_rd)
			busy_cnt_q <= 17'(STD_CYC);
		else if (busy_cnt_q != 17'd0)
			busy_cnt_q <= busy_cnt_q - 17'd1;
	end
	assign internal_work_flag = (busy_cnt_q != 17'd0);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vis_q   <= 1'b0;
			mark_q  <= 1'b0;
			flash_q <= 1'b0;
		end else if (cmd_wr && cmd == CLD_ONOFF) begin
			vis_q   <= wbyte[B_VISIBLE];
			mark_q  <= wbyte[B_MARK];
			flash_q <= wbyte[B_FLASH];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			width_q <= RST_WIDTH;
			two_q   <= 1'b0;
			tall_q  <= 1'b0;
		end else if (cmd_wr && cmd == CLD_FUNC) begin
			width_q <= wbyte[B_WIDTH];
			two_q   <= wbyte[B_TWO];
			tall_q  <= wbyte[B_TALL];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			step_up_dir_q <= RST_STEPUP;
			auto_pan_q    <= 1'b0;
		end else if (cmd_wr && cmd == CLD_ENTRY) begin
			step_up_dir_q <= wbyte[B_STEPUP];
			auto_pan_q    <= wbyte[B_AUTOPAN];
		end else if (cmd_wr && cmd == CLD_CLEAR)
			step_up_dir_q <= 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ptr_q       <= 7'd0;
			glyph_sel_q <= 1'b0;
		end else if (cmd_wr) begin
			unique case (cmd)
				CLD_CLEAR, CLD_HOME: begin
					ptr_q       <= 7'd0;
					glyph_sel_q <= 1'b0;
				end
				CLD_GLYPH: begin
					ptr_q       <= {1'b0, wbyte[5:0]};
					glyph_sel_q <= 1'b1;
				end
				CLD_SCREEN: begin
					ptr_q       <= wbyte[6:0];
					glyph_sel_q <= 1'b0;
				end
				// of the shift instructions, only a cursor move steps the pointer
				CLD_SHIFT:
					if (!wbyte[B_PAN])
						ptr_q <= step(ptr_q, wbyte[B_RIGHT], glyph_sel_q, two_q);
				CLD_NONE, CLD_ENTRY, CLD_ONOFF, CLD_FUNC: ;
			endcase
		end else if (dat_wr || dat_rd)
			ptr_q <= step(ptr_q, step_up_dir_q, glyph_sel_q, two_q);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pan_offset_q <= 7'd0;
		else if (cmd_wr && (cmd == CLD_CLEAR || cmd == CLD_HOME))
			pan_offset_q <= 7'd0;
		// display pan, both rows share one offset
		else if (cmd_wr && cmd == CLD_SHIFT && wbyte[B_PAN])
			pan_offset_q <= pan_step(pan_offset_q, !wbyte[B_RIGHT], line_len);
		// pan only on screen writes with auto pan
		else if (dat_wr && !glyph_sel_q && auto_pan_q)
			pan_offset_q <= pan_step(pan_offset_q, step_up_dir_q, line_len);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			clr_cnt_q <= 8'd0;
		else if (cmd_wr && cmd == CLD_CLEAR)
			clr_cnt_q <= 8'(SCREEN_DEPTH);
		else if (clr_cnt_q != 8'd0)
			clr_cnt_q <= clr_cnt_q - 8'd1;
	end

	// memories hold no reset; the fill runs inside the clear busy time
	always_ff @(posedge pclk) begin
		// space fill, one entry per cycle
		if (clr_cnt_q != 8'd0)
			screen_text_mem[7'(clr_cnt_q - 8'd1)] <= SPACE_CODE;
		// data write to the addressed memory
		else if (dat_wr && !glyph_sel_q)
			screen_text_mem[ptr_q] <= wbyte;
		if (dat_wr && glyph_sel_q)
			glyph_pattern_mem[ptr_q[5:0]] <= wbyte;
	end

	// flash phase toggles each blink period
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			blink_cnt_q   <= 24'd0;
			flash_phase_q <= 1'b0;
		end else if (blink_cnt_q == 24'(BLINK_CYCLES - 1)) begin
			blink_cnt_q   <= 24'd0;
			flash_phase_q <= !flash_phase_q;
		end else
			blink_cnt_q   <= blink_cnt_q + 24'd1;
	end

	// scan: row base plus panned column, each row wraps within itself
	logic [7:0] col_sum;
	logic [6:0] scan_col_w;
	logic [6:0] scan_addr;
	assign col_sum    = {1'b0, scan_col} + {1'b0, pan_offset_q};
	assign scan_col_w = (col_sum >= {1'b0, line_len}) ? 7'(col_sum - {1'b0, line_len})
		: col_sum[6:0];
	assign scan_addr  = (two_q && scan_row) ? ROW2_BASE + scan_col_w : scan_col_w;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scan_char_q  <= 8'h00;
			scan_blank_q <= 1'b1;
			scan_mark_q  <= 1'b0;
			glyph_row_q  <= 8'h00;
		end else begin
			// blanked while panel off, memory untouched
			scan_char_q  <= vis_q ? screen_text_mem[scan_addr] : SPACE_CODE;
			scan_blank_q <= !vis_q || (flash_q && flash_phase_q && !glyph_sel_q
				&& scan_addr == ptr_q);
			scan_mark_q  <= vis_q && mark_q && !glyph_sel_q && scan_addr == ptr_q;
			glyph_row_q  <= glyph_pattern_mem[glyph_scan_addr];
		end
	end

	assign mark_dot_row       = tall_q ? MARK_ROW_TALL : MARK_ROW_SHORT;
	assign panel_visible_on   = vis_q;
	assign pointer_mark_shown = mark_q;
	assign char_flash_on      = flash_q;
	assign bus_width_sel      = width_q;
	assign two_row_layout     = two_q;
	assign glyph_tall_sel     = tall_q;
	assign ram_pointer        = ptr_q;

endmodule

// ---- verif/cldec_props.sv ----
`timescale 1ns/1ps
module cldec_props
	import cldec_pkg::*;
#(
	parameter int CLEAR_CYCLES = CLEAR_CYC,
	parameter int HOME_CYCLES  = HOME_CYC,
	parameter int BLINK_CYCLES = BLINK_CYC
) (
	// clock, reset, bus
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic [7:0]  paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	// state
	input wire logic        internal_work_flag,
	input wire logic        panel_visible_on,
	input wire logic        pointer_mark_shown,
	input wire logic        char_flash_on,
	input wire logic        bus_width_sel,
	input wire logic        glyph_tall_sel,
	input wire logic [6:0]  ram_pointer,
	input wire logic [6:0]  pan_offset_q,
	input wire logic [3:0]  mark_dot_row
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// accepted instruction write in byte mode
	logic go;
	assign go = psel && penable && pwrite && paddr == OFF_INSTR && !internal_work_flag
		&& bus_width_sel;

	a_onoff_apply: assert property (go && pwdata[7:3] == 5'h01 |=>
		{panel_visible_on, pointer_mark_shown, char_flash_on} == $past(pwdata[2:0]))
		else $error("on/off bits not applied");
	a_busy_start: assert property (go |=> internal_work_flag)
		else $error("no busy after instruction");
	a_status_read: assert property (bus_width_sel && psel && penable && !pwrite
		&& paddr == OFF_INSTR
		|-> prdata[7:0] == {$past(internal_work_flag), $past(ram_pointer)})
		else $error("status read wrong");
	a_upper_zero: assert property (prdata[31:8] == 24'h00_0000)
		else $error("upper read bits set");
	a_busy_refuse: assert property (internal_work_flag && psel && penable && pwrite
		|=> $stable(ram_pointer) && $stable(panel_visible_on))
		else $error("write taken while busy");
	a_screen_set: assert property (go && pwdata[7] |=> ram_pointer == $past(pwdata[6:0]))
		else $error("screen address not loaded");
	a_glyph_set: assert property (go && pwdata[7:6] == 2'b01
		|=> ram_pointer == {1'b0, $past(pwdata[5:0])})
		else $error("glyph address not loaded");
	a_clear_home: assert property (go && pwdata[7:2] == 6'h00 && pwdata[1:0] != 2'b00
		|-> ##[1:256] (ram_pointer == 7'h00 && pan_offset_q == 7'h00))
		else $error("pointer or pan not zeroed");
	a_pan_keeps: assert property (go && pwdata[7:3] == 5'h03 |=> $stable(ram_pointer))
		else $error("display shift moved pointer");
	a_tall_row: assert property (glyph_tall_sel |-> mark_dot_row == MARK_ROW_TALL)
		else $error("mark row wrong");

	cover property (go && pwdata[7:0] == 8'h01);
	cover property (go && pwdata[7]);
	cover property (psel && penable && !pwrite && paddr == OFF_DATA);
endmodule

bind cldec_top cldec_props #(.CLEAR_CYCLES(CLEAR_CYCLES), .HOME_CYCLES(HOME_CYCLES),
	.BLINK_CYCLES(BLINK_CYCLES)) u_props (.pclk(pclk), .presetn(presetn), .paddr(paddr),
	.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
	.internal_work_flag(internal_work_flag), .panel_visible_on(panel_visible_on),
	.pointer_mark_shown(pointer_mark_shown), .char_flash_on(char_flash_on),
	.bus_width_sel(bus_width_sel), .glyph_tall_sel(glyph_tall_sel),
	.ram_pointer(ram_pointer), .pan_offset_q(pan_offset_q), .mark_dot_row(mark_dot_row));

// ---- verif/cldec_host.sv ----
`timescale 1ns/1ps
module cldec_host
	import cldec_pkg::*;
(
	// clock
	input wire logic        pclk,
	// bus request
	output logic            psel,
	output logic            penable,
	output logic            pwrite,
	output logic [7:0]      paddr,
	output logic [31:0]     pwdata,
	// answer
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr
);
	logic last_err;
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
	end
	// one transfer, entered just after a rising edge
	task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d,
		output logic [7:0] q);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= {24'h00_0000, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata[7:0];
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// idle data must not look like the last byte
		pwdata <= ~pwdata;
		@(posedge pclk);
	endtask
	// poll status until work flag clears
	task automatic wait_idle();
		logic [7:0] s;
		s = 8'hFF;
		while (s[7] !== 1'b0) xfer(OFF_INSTR, 1'b0, 8'h00, s);
	endtask
endmodule

// ---- verif/char_lcd_instruction_decoder_bench.sv ----
`timescale 1ns/1ps
module char_lcd_instruction_decoder_bench import cldec_pkg::*;;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, scan_blank_q;
	logic        panel_visible_on, pointer_mark_shown, char_flash_on, bus_width_sel;
	logic        two_row_layout, glyph_tall_sel, internal_work_flag, scan_row;
	logic [7:0]  paddr, q, scan_char;
	logic [31:0] pwdata, prdata;
	logic [6:0]  ram_pointer, pan_offset_q, scan_col;
	logic [5:0]  gsa;
	logic [3:0]  mark_dot_row;
	int          fails, cmp_count, cyc;

	// short counts keep the run brief
	cldec_top #(.CLEAR_CYCLES(200), .HOME_CYCLES(20), .BLINK_CYCLES(16)) dut (.pclk(pclk),
		.presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.scan_row(scan_row), .scan_col(scan_col), .glyph_scan_addr(gsa),
		.scan_char_q(scan_char),
		.scan_blank_q(scan_blank_q), .scan_mark_q(), .glyph_row_q(),
		.internal_work_flag(internal_work_flag), .panel_visible_on(panel_visible_on),
		.pointer_mark_shown(pointer_mark_shown), .char_flash_on(char_flash_on),
		.bus_width_sel(bus_width_sel), .two_row_layout(two_row_layout),
		.glyph_tall_sel(glyph_tall_sel), .ram_pointer(ram_pointer),
		.pan_offset_q(pan_offset_q), .mark_dot_row(mark_dot_row), .flash_phase_q());
	cldec_host h (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cmd(input logic [7:0] d);
		h.xfer(OFF_INSTR, 1'b1, d, q);
		h.wait_idle();
	endtask
	task automatic dwr(input logic [7:0] d);
		h.xfer(OFF_DATA, 1'b1, d, q);
		h.wait_idle();
	endtask
	task automatic drd(input logic [7:0] exp);
		h.xfer(OFF_DATA, 1'b0, 8'h00, q);
		chk(q, exp);
		h.wait_idle();
	endtask
	// narrow mode: high half first, on bits 7..4
	task automatic nrd(input logic [7:0] a, output logic [7:0] b);
		logic [7:0] hi;
		h.xfer(a, 1'b0, 8'h00, hi);
		h.xfer(a, 1'b0, 8'h00, q);
		b = {hi[7:4], q[7:4]};
	endtask
	// polls in pairs so the half counter stays aligned
	task automatic nwait();
		logic [7:0] s;
		s = 8'hFF;
		while (s[7] !== 1'b0) nrd(OFF_INSTR, s);
	endtask
	task automatic nwr(input logic [7:0] a, input logic [7:0] d);
		h.xfer(a, 1'b1, {d[7:4], 4'h0}, q);
		h.xfer(a, 1'b1, {d[3:0], 4'h0}, q);
		nwait();
	endtask
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic t_reset();
		h.xfer(OFF_INSTR, 1'b0, 8'h00, q);
		chk(q, 8'h00);
		chk({7'h00, bus_width_sel}, 8'h01);
		h.xfer(8'h08, 1'b0, 8'h00, q);
		chk({7'h00, h.last_err}, 8'h01);
		$display("reset test done");
	endtask
	task automatic t_onoff();
		cmd(8'h0B);
		chk({5'h00, panel_visible_on, pointer_mark_shown, char_flash_on}, 8'h03);
		chk({7'h00, scan_blank_q}, 8'h01);
		cmd(8'h0F);
		chk({5'h00, panel_visible_on, pointer_mark_shown, char_flash_on}, 8'h07);
		// second write lands while busy and must be dropped
		h.xfer(OFF_INSTR, 1'b1, 8'h08, q);
		h.xfer(OFF_INSTR, 1'b1, 8'h0F, q);
		h.wait_idle();
		chk({5'h00, panel_visible_on, pointer_mark_shown, char_flash_on}, 8'h00);
		cmd(8'h0C);
		$display("on/off test done");
	endtask
	task automatic t_clear();
		cmd(8'h85);
		dwr(8'h41);
		cmd(8'h04);
		cmd(8'h01);
		chk({1'b0, ram_pointer}, 8'h00);
		cmd(8'h85);
		drd(8'h20);
		chk({1'b0, ram_pointer}, 8'h06);
		chk(scan_char, 8'h20);
		$display("clear test done");
	endtask
	task automatic t_data();
		cmd(8'h38);
		chk({7'h00, two_row_layout}, 8'h01);
		cmd(8'hA7);
		dwr(8'h55);
		chk({1'b0, ram_pointer}, 8'h40);
		cmd(8'hA7);
		drd(8'h55);
		cmd(8'h43);
		dwr(8'h1F);
		chk({1'b0, ram_pointer}, 8'h04);
		cmd(8'h43);
		drd(8'h1F);
		$display("data test done");
	endtask
	task automatic t_pan();
		cmd(8'h07);
		cmd(8'h80);
		dwr(8'h41);
		chk({1'b0, pan_offset_q}, 8'h01);
		drd(8'h20);
		chk({1'b0, pan_offset_q}, 8'h01);
		cmd(8'h18);
		chk({1'b0, ram_pointer}, 8'h02);
		chk({1'b0, pan_offset_q}, 8'h02);
		cmd(8'h14);
		chk({1'b0, ram_pointer}, 8'h03);
		cmd(8'h02);
		chk({ram_pointer, 1'b0} | {1'b0, pan_offset_q}, 8'h00);
		cmd(8'h34);
		chk({4'h0, mark_dot_row}, 8'h0A);
		cmd(8'h30);
		chk({4'h0, mark_dot_row}, 8'h07);
		$display("pan test done");
	endtask
	task automatic t_narrow();
		logic [7:0] s;
		h.xfer(OFF_INSTR, 1'b1, 8'h20, q);
		nwait();
		chk({7'h00, bus_width_sel}, 8'h00);
		nwr(OFF_INSTR, 8'h90);
		nrd(OFF_INSTR, s);
		chk(s, 8'h10);
		nwr(OFF_DATA, 8'h4B);
		nwr(OFF_INSTR, 8'h90);
		nrd(OFF_DATA, s);
		chk(s, 8'h4B);
		nwait();
		h.xfer(OFF_INSTR, 1'b1, 8'h30, q);
		h.xfer(OFF_INSTR, 1'b1, 8'h00, q);
		h.wait_idle();
		chk({7'h00, bus_width_sel}, 8'h01);
		$display("narrow test done");
	endtask

	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	// hang guard, well above the expected run length
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			fails++;
			wrap_up();
		end
	end
	initial begin
		presetn = 1'b0;
		scan_row = 1'b0;
		scan_col = 7'h00;
		gsa = 6'h00;
		fails = 0;
		cmp_count = 0;
		cyc = 0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_onoff();
		t_clear();
		t_data();
		t_pan();
		t_narrow();
		wrap_up();
	end
endmodule
